//--- rtl/ccr_control_registers.sv
// Purpose: write-only control registers behind the three-wire serial port
// Assumes: all inputs synchronous to clock; serial clock sampled as a level
// Notes:   analog effects are represented by the register fields driven out
//          normal control mode presents the defaults, with the edge taken from the pin
//          writes to addresses with no register here are dropped without trace
//
// How it works
// - strobe phase matters only in double rate
// - rate bit 0: word on both edges
// - rate bit 1: one word per period
// - single rate edge: 1 rising, 0 falling
// - 8-bit offset magnitude, linear, monotonic
// - offset sign: 0 positive, 1 negative
// - 9-bit gain, default 100h, 700 mV
// - gain change needs no recalibration
// - 9-bit fine delay, up to 110 ps
// - registers act only in extended mode
// - phase adjust only when enable set
`timescale 1ns/100ps
module ccr_control_registers
  import ccr_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // serial control port
  input  wire logic       select_n,
  input  wire logic       serial_clock,
  input  wire logic       serial_data,
  // mode pins used in normal control mode
  input  wire logic       extended_mode,
  input  wire logic       edge_select_pin,
  // effective settings
  output logic            double_rate,
  output logic            strobe_centered,
  output logic            data_on_rising,
  output logic            data_on_falling,
  output logic [7:0]      offset_magnitude,
  output logic            offset_negative,
  output logic [8:0]      gain_value,
  output logic [8:0]      fine_delay,
  output logic            phase_adjust_enable
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic       sclk_q;
    ccr_ctrl_s  regs;
    logic       double_rate;
    logic       strobe_centered;
    logic       data_on_rising;
    logic       data_on_falling;
    logic [7:0] offset_magnitude;
    logic       offset_negative;
    logic [8:0] gain_value;
    logic [8:0] fine_delay;
    logic       phase_adjust_enable;
  } ccr_top_state_s;

  localparam ccr_ctrl_s REG_RESET = '{
    strobe_phase_select: RST_STROBE_PHASE,
    rate_select_n:       RST_RATE_SEL_N,
    edge_select:         RST_EDGE_SEL,
    offset_magnitude:    RST_OFFSET,
    offset_negative:     RST_OFFSET_SIGN,
    gain_value:          RST_GAIN,
    fine_delay:          RST_FINE,
    phase_adjust_enable: RST_PHASE_ENA
  };

  // output reset values follow from the register defaults, so the two never disagree
  localparam ccr_top_state_s STATE_RESET = '{
    sclk_q:              1'b0,
    regs:                REG_RESET,
    double_rate:         ~RST_RATE_SEL_N,
    strobe_centered:     ~RST_RATE_SEL_N & RST_STROBE_PHASE,
    data_on_rising:      ~RST_RATE_SEL_N | RST_EDGE_SEL,
    data_on_falling:     ~RST_RATE_SEL_N | ~RST_EDGE_SEL,
    offset_magnitude:    RST_OFFSET,
    offset_negative:     RST_OFFSET_SIGN,
    gain_value:          RST_GAIN,
    fine_delay:          RST_PHASE_ENA ? RST_FINE : 9'h000,
    phase_adjust_enable: RST_PHASE_ENA
  };

  ccr_top_state_s state;
  ccr_top_state_s next_state;
  ccr_write_s     write;
  logic           sclk_rise;

  // sclk_q rests low like the idle serial clock, so reset brings no false edge
  assign sclk_rise = serial_clock & ~state.sclk_q;

  // the receiver owns the bit count; only whole frames reach this module
  ccr_frame_rx u_frame_rx (
    .clock     (clock),
    .rst_b     (rst_b),
    .select_n  (select_n),
    .sclk_rise (sclk_rise),
    .sdata     (serial_data),
    .write     (write)
  );

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // eff is what the hardware obeys: stored registers, or defaults plus the edge pin in normal mode
    ccr_ctrl_s eff;
    eff               = state.regs;
    next_state        = state;
    next_state.sclk_q = serial_clock;
    //////////////////////////////////////////////////////////////////////////////
    // register writes
    // filler bits are not checked; a host slip there is harmless
    // whole frames only
    if (write.valid) begin
      unique case (write.addr)
        ADDR_CLOCKING: begin
          next_state.regs.strobe_phase_select = write.data[POS_STROBE_PHASE];
          next_state.regs.rate_select_n       = write.data[POS_RATE_SEL_N];
          next_state.regs.edge_select         = write.data[POS_EDGE_SEL];
        end
        ADDR_OFFSET: begin
          next_state.regs.offset_magnitude = write.data[POS_OFFSET_LSB +: 8];
          next_state.regs.offset_negative  = write.data[POS_OFFSET_SIGN];
        end
        ADDR_GAIN: begin
          next_state.regs.gain_value = write.data[POS_NINE_LSB +: 9];
        end
        ADDR_FINE: begin
          next_state.regs.fine_delay = write.data[POS_NINE_LSB +: 9];
        end
        ADDR_COARSE: begin
          next_state.regs.phase_adjust_enable = write.data[POS_PHASE_ENA];
        end
        default: begin
          next_state.regs = state.regs;
        end
      endcase
    end
    if (!extended_mode) begin
      eff.strobe_phase_select = RST_STROBE_PHASE;
      eff.rate_select_n       = RST_RATE_SEL_N;
      eff.edge_select         = edge_select_pin;
      eff.offset_magnitude    = RST_OFFSET;
      eff.offset_negative     = RST_OFFSET_SIGN;
      eff.gain_value          = RST_GAIN;
      eff.fine_delay          = RST_FINE;
      eff.phase_adjust_enable = RST_PHASE_ENA;
    end
    //////////////////////////////////////////////////////////////////////////////
    // strobe edges
    if (!eff.rate_select_n) begin
      next_state.double_rate     = 1'b1;
      next_state.data_on_rising  = 1'b1;
      next_state.data_on_falling = 1'b1;
      next_state.strobe_centered = eff.strobe_phase_select;
    end else begin
      next_state.double_rate     = 1'b0;
      next_state.strobe_centered = 1'b0;
      next_state.data_on_rising  = eff.edge_select;
      next_state.data_on_falling = ~eff.edge_select;
    end
    //////////////////////////////////////////////////////////////////////////////
    // analog trims
    // offset magnitude passed on
    next_state.offset_magnitude = eff.offset_magnitude;
    next_state.offset_negative  = eff.offset_negative;
    next_state.gain_value       = eff.gain_value;
    next_state.fine_delay          = eff.phase_adjust_enable ? eff.fine_delay : 9'h000;
    next_state.phase_adjust_enable = eff.phase_adjust_enable;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  // no power-down input here, so contents survive it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flop
  assign double_rate         = state.double_rate;
  assign strobe_centered     = state.strobe_centered;
  assign data_on_rising      = state.data_on_rising;
  assign data_on_falling     = state.data_on_falling;
  assign offset_magnitude    = state.offset_magnitude;
  assign offset_negative     = state.offset_negative;
  assign gain_value          = state.gain_value;
  assign fine_delay          = state.fine_delay;
  assign phase_adjust_enable = state.phase_adjust_enable;

endmodule // ccr_control_registers

//--- rtl/ccr_pkg.sv
// Purpose: shared constants and carriers for the converter control registers
// Assumes: serial frames arrive sampled synchronously to clock
// Notes:   register addresses are the 4-bit frame addresses
package ccr_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // frame layout
  localparam int          FRAME_BITS     = 32;
  localparam int          HEADER_BITS    = 12;
  localparam logic [11:0] FRAME_HEADER   = 12'h001;
  localparam int          ADDR_BITS      = 4;
  localparam int          DATA_BITS      = 16;

  //////////////////////////////////////////////////////////////////////////////
  // register addresses
  localparam logic [3:0]  ADDR_CLOCKING  = 4'h1;
  localparam logic [3:0]  ADDR_OFFSET    = 4'h2;
  localparam logic [3:0]  ADDR_GAIN      = 4'h3;
  localparam logic [3:0]  ADDR_FINE      = 4'hD;
  localparam logic [3:0]  ADDR_COARSE    = 4'hE;

  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int          POS_STROBE_PHASE = 11;
  localparam int          POS_RATE_SEL_N   = 10;
  localparam int          POS_EDGE_SEL     = 8;
  localparam int          POS_OFFSET_LSB   = 8;
  localparam int          POS_OFFSET_SIGN  = 7;
  localparam int          POS_NINE_LSB     = 7;
  localparam int          POS_PHASE_ENA    = 15;

  //////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic        RST_STROBE_PHASE = 1'b1;
  localparam logic        RST_RATE_SEL_N   = 1'b1;
  localparam logic        RST_EDGE_SEL     = 1'b0;
  localparam logic [7:0]  RST_OFFSET       = 8'h00;
  localparam logic        RST_OFFSET_SIGN  = 1'b0;
  localparam logic [8:0]  RST_GAIN         = 9'h100;
  localparam logic [8:0]  RST_FINE         = 9'h000;
  localparam logic        RST_PHASE_ENA    = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic       strobe_phase_select;
    logic       rate_select_n;
    logic       edge_select;
    logic [7:0] offset_magnitude;
    logic       offset_negative;
    logic [8:0] gain_value;
    logic [8:0] fine_delay;
    logic       phase_adjust_enable;
  } ccr_ctrl_s;

  typedef struct packed {
    logic       valid;
    logic [3:0] addr;
    logic [15:0] data;
  } ccr_write_s;

endpackage : ccr_pkg

//--- rtl/ccr_frame_rx.sv
// Purpose: shifts serial frames and emits one write per good frame
// Assumes: sclk_rise marks a serial clock edge carrying sdata
// Notes:   select high aborts the partial frame
`timescale 1ns/100ps
module ccr_frame_rx
  import ccr_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // serial port
  input  wire logic       select_n,
  input  wire logic       sclk_rise,
  input  wire logic       sdata,
  // decoded write
  output ccr_write_s      write
);

  typedef struct packed {
    logic [31:0] shift;
    logic [5:0]  count;
    ccr_write_s  write;
  } ccr_rx_state_s;

  ccr_rx_state_s state;
  ccr_rx_state_s next_state;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state             = state;
    next_state.write.valid = 1'b0;
    if (select_n) begin
      next_state.count = 6'h00;
    end else if (sclk_rise) begin
      next_state.shift = {state.shift[30:0], sdata};
      if (state.count == 6'(FRAME_BITS - 1)) begin
        next_state.count = 6'h00;
        if (state.shift[30:19] == FRAME_HEADER) begin
          next_state.write.valid = 1'b1;
          next_state.write.addr  = state.shift[18:15];
          next_state.write.data  = {state.shift[14:0], sdata};
        end
      end else begin
        next_state.count = state.count + 6'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign write = state.write;

endmodule // ccr_frame_rx

//--- verif/ccr_host_model.sv
// Purpose: host side of the three-wire control port
// Assumes: driven off the falling clock edge
// Notes:   serial clock rests low between frames
`timescale 1ns/100ps
module ccr_host_model (
  // clock
  input  wire logic clock,
  // serial port
  output logic      select_n,
  output logic      serial_clock,
  output logic      serial_data
);
  initial begin
    select_n = 1'b1;
    serial_clock = 1'b0;
    serial_data = 1'b0;
  end
  task automatic send(input logic [11:0] hdr, input logic [3:0] adr, input logic [15:0] dat);
    logic [31:0] f;
    f = {hdr, adr, dat};
    for (int i = 31; i >= 0; i--) begin
      @(negedge clock);
      select_n = 1'b0;
      serial_clock = 1'b1;
      serial_data = f[i];
      @(negedge clock);
      serial_clock = 1'b0;
    end
    @(negedge clock);
    select_n = 1'b1;
    // released line shows the inverse, not a held value
    serial_data = ~f[0];
  endtask
endmodule // ccr_host_model

//--- verif/ccr_control_registers_checker.sv
// Purpose: port-level checks of the control registers
// Assumes: one clock domain
// Notes:   bound onto every instance
`timescale 1ns/100ps
module ccr_control_registers_checker (
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       select_n,
  input wire logic       extended_mode,
  input wire logic       edge_select_pin,
  input wire logic       double_rate,
  input wire logic       strobe_centered,
  input wire logic       data_on_rising,
  input wire logic       data_on_falling,
  input wire logic [7:0] offset_magnitude,
  input wire logic [8:0] gain_value,
  input wire logic [8:0] fine_delay,
  input wire logic       phase_adjust_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_centered; strobe_centered |-> double_rate; endproperty
  a_centered: assert property (p_centered) else $error("centred strobe in single rate");
  property p_both; double_rate |-> data_on_rising && data_on_falling; endproperty
  a_both: assert property (p_both) else $error("double rate lacks an edge");
  property p_one; !double_rate |-> data_on_rising != data_on_falling; endproperty
  a_one: assert property (p_one) else $error("single rate not on one edge");
  property p_pin;
    !extended_mode ##1 (!extended_mode && $stable(edge_select_pin)) |-> data_on_rising == edge_select_pin;
  endproperty
  a_pin: assert property (p_pin) else $error("edge pin not followed");
  property p_normal;
    !extended_mode ##1 !extended_mode |-> !double_rate && gain_value == 9'h100 && offset_magnitude == 8'h00;
  endproperty
  a_normal: assert property (p_normal) else $error("registers act in normal mode");
  property p_gate; !phase_adjust_enable |-> fine_delay == 9'h000; endproperty
  a_gate: assert property (p_gate) else $error("fine delay without enable");
  property p_quiet;
    (select_n && extended_mode) [*4] |-> $stable(gain_value) && $stable(offset_magnitude);
  endproperty
  a_quiet: assert property (p_quiet) else $error("update without a frame");
  property p_rst; $rose(rst_b) |-> gain_value == 9'h100 && data_on_falling; endproperty
  a_rst: assert property (p_rst) else $error("bad reset defaults");
endmodule // ccr_control_registers_checker
bind ccr_control_registers ccr_control_registers_checker chk (
  .clock               (clock),
  .rst_b               (rst_b),
  .select_n            (select_n),
  .extended_mode       (extended_mode),
  .edge_select_pin     (edge_select_pin),
  .double_rate         (double_rate),
  .strobe_centered     (strobe_centered),
  .data_on_rising      (data_on_rising),
  .data_on_falling     (data_on_falling),
  .offset_magnitude    (offset_magnitude),
  .gain_value          (gain_value),
  .fine_delay          (fine_delay),
  .phase_adjust_enable (phase_adjust_enable)
);

//--- verif/ccr_control_registers_bench.sv
// Purpose: self-checking bench for the control registers
// Assumes: inputs change on the falling edge
// Notes:   results are compared four cycles after each check point, which follows reset release, one or more frames, or a mode change
`timescale 1ns/100ps
module ccr_control_registers_bench;
  logic clock = 1'b0, rst_b = 1'b0, extended_mode = 1'b1, edge_select_pin = 1'b0;
  wire logic select_n, serial_clock, serial_data;
  logic double_rate, strobe_centered, data_on_rising, data_on_falling, offset_negative, phase_adjust_enable;
  logic [7:0] offset_magnitude;
  logic [8:0] gain_value, fine_delay;
  int failures = 0, checked = 0;
  logic [31:0] seed = 32'hB9AD027D;
  logic [31:0] q[$];
  event due;
  logic rn = 1'b1, ed = 1'b0, ph = 1'b1, sg = 1'b0, en = 1'b0;
  logic [7:0] om = 8'h00;
  logic [8:0] g = 9'h100, f = 9'h000;
  always #25 clock = ~clock;
  ccr_control_registers uut (
    .clock               (clock),
    .rst_b               (rst_b),
    .select_n            (select_n),
    .serial_clock        (serial_clock),
    .serial_data         (serial_data),
    .extended_mode       (extended_mode),
    .edge_select_pin     (edge_select_pin),
    .double_rate         (double_rate),
    .strobe_centered     (strobe_centered),
    .data_on_rising      (data_on_rising),
    .data_on_falling     (data_on_falling),
    .offset_magnitude    (offset_magnitude),
    .offset_negative     (offset_negative),
    .gain_value          (gain_value),
    .fine_delay          (fine_delay),
    .phase_adjust_enable (phase_adjust_enable)
  );
  ccr_host_model host (
    .clock        (clock),
    .select_n     (select_n),
    .serial_clock (serial_clock),
    .serial_data  (serial_data)
  );
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] want();
    logic d;
    d = ~rn;
    if (!extended_mode) return {2'b00, edge_select_pin, ~edge_select_pin, 8'h00, 1'b0, 9'h100, 10'h000};
    return {d, d & ph, d | ed, d | ~ed, om, sg, g, en ? f : 9'h000, en};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    host.send(12'h001, a, d);
  endtask
  task automatic chk();
    q.push_back(want());
    repeat (4) @(posedge clock);
    #1 -> due;
  endtask
  task automatic compare_outputs(input logic [31:0] e);
    logic [31:0] s;
    s = {double_rate, strobe_centered, data_on_rising, data_on_falling, offset_magnitude, offset_negative,
         gain_value, fine_delay, phase_adjust_enable};
    checked++;
    if (s !== e) begin
      failures++;
      $display("mismatch outputs expected %h seen %h", e, s);
    end
  endtask
  always @(due) begin
    compare_outputs(q.pop_front());
  end
  task automatic tally_and_finish();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock) rst_b = 1'b1;
    chk();
    for (int i = 0; i < 8; i++) begin
      {ph, rn, ed} = i[2:0];
      wr(4'h1, {4'h8, ph, rn, 1'b1, ed, 8'hFF});
      chk();
    end
    $display("test clocking done");
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      {om, sg, f} = seed[17:0];
      g = 9'h0C0 + 9'(seed[25:18]);
      wr(4'h2, {om, sg, 7'h7F});
      wr(4'h3, {g, 7'h7F});
      wr(4'hD, {f, 7'h7F});
      chk();
      en = ~en;
      wr(4'hE, {en, 15'h03FF});
      chk();
    end
    $display("test values done");
    host.send(12'h003, 4'h3, 16'h007F);
    chk();
    wr(4'h4, 16'h007F);
    chk();
    $display("test refusals done");
    @(negedge clock) extended_mode = 1'b0;
    chk();
    @(negedge clock) edge_select_pin = 1'b1;
    chk();
    @(negedge clock) extended_mode = 1'b1;
    chk();
    $display("test modes done");
    tally_and_finish();
  end
  initial begin
    #1_000_000;
    failures++;
    tally_and_finish();
  end
endmodule // ccr_control_registers_bench
